//--- verilog/usdp_consts.svh
// Address map, field positions, reset values and timing counts of the shadow data port.
`ifndef USDP_CONSTS_SVH
`define USDP_CONSTS_SVH

// ----------------------------------------
// Address map
// ----------------------------------------
`define USDP_SHADOW_BASE 32'h5000_1030
`define USDP_SHADOW_ALIAS11 32'h5000_105c
`define USDP_SHADOW_SPAN 32'h0000_0040
`define USDP_CTRL_ADDR 32'h5000_1080
`define USDP_STAT_ADDR 32'h5000_1084

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define USDP_CTRL_FIFO_EN_BIT 0
`define USDP_CTRL_IR_MODE_BIT 1
`define USDP_STAT_AVAIL_BIT 0
`define USDP_STAT_OVERRUN_BIT 1
`define USDP_STAT_TX_HOLDING_EMPTY_BIT 5
`define USDP_STAT_TX_IDLE_BIT 6
`define USDP_DATA_RESET 8'h00
`define USDP_RESP_OKAY 2'b00
`define USDP_RESP_SLVERR 2'b10

// ----------------------------------------
// Timing
// ----------------------------------------
`define USDP_CLK_HZ 25000000
`define USDP_BAUD_BPS 115200
`define USDP_BIT_CYCLES (`USDP_CLK_HZ / `USDP_BAUD_BPS)
`define USDP_IR_PULSE_NUM 3
`define USDP_IR_PULSE_DEN 16
`define USDP_RX_DEPTH 8
`define USDP_TX_DEPTH 16

`endif

//--- verilog/usdp_pkg.sv
// Types shared by the shadow data port modules.
package usdp_pkg;

    typedef enum logic [3:0] {
        USDP_LN_IDLE = 4'b0001,
        USDP_LN_START = 4'b0010,
        USDP_LN_DATA = 4'b0100,
        USDP_LN_STOP = 4'b1000
    } usdp_line_state_t;

    typedef struct packed {
        logic fifo_en;
        logic ir_mode;
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_strb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [7:0] rx_hold;
        logic rx_hold_valid;
        logic overrun;
        logic [7:0] tx_hold;
        logic tx_hold_valid;
        usdp_line_state_t tx_state;
        logic [15:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_shift;
        logic tx_line;
        logic tx_serial;
        logic tx_ir_n;
        usdp_line_state_t rx_state;
        logic [15:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_shift;
        logic sin_meta;
        logic sin_sync;
        logic ir_meta;
        logic ir_sync;
    } usdp_state_t;

endpackage

//--- verilog/usdp_fifo.sv
// Synchronous first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module usdp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
        $error("usdp_fifo needs a power-of-two depth of at least two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } usdp_fifo_state_t;

    usdp_fifo_state_t fifo_reg;
    usdp_fifo_state_t fifo_next;
    logic push;
    logic pop;

    assign in_ready_o = fifo_reg.cnt != (AW+1)'(DEPTH);
    assign out_valid_o = fifo_reg.cnt != '0;
    // The head word comes straight from a storage flip-flop, never from the input.
    assign out_data_o = fifo_reg.mem[fifo_reg.rp];

    always_comb begin
        fifo_next = fifo_reg;
        push = in_valid_i & in_ready_o;
        pop = out_ready_i & out_valid_o;
        if (push) begin
            fifo_next.mem[fifo_reg.wp] = in_data_i;
            fifo_next.wp = fifo_reg.wp + 1'b1;
        end
        if (pop) begin
            fifo_next.rp = fifo_reg.rp + 1'b1;
        end
        fifo_next.cnt = fifo_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            fifo_next.wp = '0;
            fifo_next.rp = '0;
            fifo_next.cnt = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end

endmodule

//--- verilog/usdp_top.sv
// Shadow receive and transmit data port of a serial UART, reached over AXI4-Lite.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "usdp_consts.svh"
module usdp_top import usdp_pkg::*; #(
    parameter int BIT_CYCLES = `USDP_BIT_CYCLES,
    parameter int RX_DEPTH = `USDP_RX_DEPTH,
    parameter int TX_DEPTH = `USDP_TX_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_serial_i,
    input wire logic rx_infrared_i,
    output logic tx_serial_o,
    output logic tx_infrared_n_o
);
    // ----------------------------------------
    // Configuration checks and derived counts
    // ----------------------------------------
    if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_bit
        $error("usdp_top needs a bit time of 4 to 65535 clocks");
    end
    localparam logic [15:0] BIT_M1 = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_M1 = 16'((BIT_CYCLES / 2) - 1);
    localparam int PULSE_RAW = (BIT_CYCLES * `USDP_IR_PULSE_NUM) / `USDP_IR_PULSE_DEN;
    localparam int PULSE = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
    localparam logic [15:0] PULSE_EDGE = 16'(BIT_CYCLES - PULSE);
    function automatic logic usdp_is_shadow(input logic [31:0] addr);
        logic [31:0] off;
        off = addr - `USDP_SHADOW_BASE;
        return (off < `USDP_SHADOW_SPAN) && (off[1:0] == 2'b00);
    endfunction
    // ----------------------------------------
    // State
    // ----------------------------------------
    usdp_state_t state_reg;
    usdp_state_t state_next;
    logic rx_push;
    logic rx_in_ready;
    logic rx_out_valid;
    logic rx_pop;
    logic [7:0] rx_out_data;
    logic tx_push;
    logic tx_in_ready;
    logic tx_out_valid;
    logic tx_pop;
    logic [7:0] tx_out_data;
    logic fifo_flush;

    // ----------------------------------------
    // Receive and transmit buffers
    // ----------------------------------------
    usdp_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .flush_i(fifo_flush),
        .in_valid_i(rx_push),
        .in_ready_o(rx_in_ready),
        .in_data_i(state_reg.rx_shift),
        .out_valid_o(rx_out_valid),
        .out_ready_i(rx_pop),
        .out_data_o(rx_out_data)
    );
    usdp_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .flush_i(fifo_flush),
        .in_valid_i(tx_push),
        .in_ready_o(tx_in_ready),
        .in_data_i(state_reg.w_data),
        .out_valid_o(tx_out_valid),
        .out_ready_i(tx_pop),
        .out_data_o(tx_out_data)
    );

    // ----------------------------------------
    // Bus handshakes and outputs
    // ----------------------------------------
    assign s_axi_awready = ~state_reg.aw_held & ~state_reg.bvalid;
    assign s_axi_wready = ~state_reg.w_held & ~state_reg.bvalid;
    assign s_axi_arready = ~state_reg.rvalid;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rresp = state_reg.rresp;
    assign s_axi_rdata = {24'h00_0000, state_reg.rdata};
    assign tx_serial_o = state_reg.tx_serial;
    assign tx_infrared_n_o = state_reg.tx_ir_n;
    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic rx_line;
        logic rx_done;
        logic tx_holding_empty_flag;
        logic tx_src_valid;
        logic [7:0] tx_src_data;
        state_next = state_reg;
        rx_line = 1'b1;
        rx_done = 1'b0;
        tx_holding_empty_flag = 1'b0;
        tx_src_valid = 1'b0;
        tx_src_data = `USDP_DATA_RESET;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        fifo_flush = 1'b0;
        // Pin inputs pass two flip-flops before anything looks at them.
        state_next.sin_meta = rx_serial_i;
        state_next.sin_sync = state_reg.sin_meta;
        state_next.ir_meta = rx_infrared_i;
        state_next.ir_sync = state_reg.ir_meta;
        tx_holding_empty_flag = state_reg.fifo_en ? ~tx_out_valid : ~state_reg.tx_hold_valid;
        // Read channel.
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !state_reg.rvalid) begin
            state_next.rvalid = 1'b1;
            state_next.rresp = `USDP_RESP_OKAY;
            state_next.rdata = 8'h00;
            if (usdp_is_shadow(s_axi_araddr)) begin
                if (state_reg.fifo_en) begin
                    rx_pop = 1'b1;
                    state_next.rdata = rx_out_valid ? rx_out_data : 8'h00;
                end else begin
                    state_next.rdata = state_reg.rx_hold;
                    state_next.rx_hold_valid = 1'b0;
                end
            end else if (s_axi_araddr == `USDP_CTRL_ADDR) begin
                state_next.rdata[`USDP_CTRL_FIFO_EN_BIT] = state_reg.fifo_en;
                state_next.rdata[`USDP_CTRL_IR_MODE_BIT] = state_reg.ir_mode;
            end else if (s_axi_araddr == `USDP_STAT_ADDR) begin
                state_next.rdata[`USDP_STAT_AVAIL_BIT] =
                    state_reg.fifo_en ? rx_out_valid : state_reg.rx_hold_valid;
                state_next.rdata[`USDP_STAT_OVERRUN_BIT] = state_reg.overrun;
                state_next.rdata[`USDP_STAT_TX_HOLDING_EMPTY_BIT] = tx_holding_empty_flag;
                state_next.rdata[`USDP_STAT_TX_IDLE_BIT] =
                    tx_holding_empty_flag & (state_reg.tx_state == USDP_LN_IDLE);
                state_next.overrun = 1'b0;
            end else begin
                state_next.rresp = `USDP_RESP_SLVERR;
            end
        end
        // Transmitter; a write later in this process wins over the hand-off.
        tx_src_valid = state_reg.fifo_en ? tx_out_valid : state_reg.tx_hold_valid;
        tx_src_data = state_reg.fifo_en ? tx_out_data : state_reg.tx_hold;
        case (state_reg.tx_state)
            USDP_LN_IDLE: begin
                state_next.tx_line = 1'b1;
                if (tx_src_valid) begin
                    tx_pop = state_reg.fifo_en;
                    state_next.tx_hold_valid = 1'b0;
                    state_next.tx_shift = tx_src_data;
                    state_next.tx_cnt = BIT_M1;
                    state_next.tx_line = 1'b0;
                    state_next.tx_state = USDP_LN_START;
                end
            end
            USDP_LN_START: begin
                if (state_reg.tx_cnt == 16'h0000) begin
                    state_next.tx_cnt = BIT_M1;
                    state_next.tx_bit = 3'h0;
                    state_next.tx_line = state_reg.tx_shift[0];
                    state_next.tx_state = USDP_LN_DATA;
                end else begin
                    state_next.tx_cnt = state_reg.tx_cnt - 16'h0001;
                end
            end
            USDP_LN_DATA: begin
                if (state_reg.tx_cnt == 16'h0000) begin
                    state_next.tx_cnt = BIT_M1;
                    state_next.tx_shift = {1'b0, state_reg.tx_shift[7:1]};
                    state_next.tx_bit = state_reg.tx_bit + 3'h1;
                    if (state_reg.tx_bit == 3'h7) begin
                        state_next.tx_line = 1'b1;
                        state_next.tx_state = USDP_LN_STOP;
                    end else begin
                        state_next.tx_line = state_reg.tx_shift[1];
                    end
                end else begin
                    state_next.tx_cnt = state_reg.tx_cnt - 16'h0001;
                end
            end
            USDP_LN_STOP: begin
                if (state_reg.tx_cnt == 16'h0000) begin
                    state_next.tx_state = USDP_LN_IDLE;
                end else begin
                    state_next.tx_cnt = state_reg.tx_cnt - 16'h0001;
                end
            end
            default: begin
                state_next.tx_state = USDP_LN_IDLE;
                state_next.tx_line = 1'b1;
            end
        endcase
        state_next.tx_serial = state_next.ir_mode ? 1'b1 : state_next.tx_line;
        state_next.tx_ir_n = ~(state_next.ir_mode & ~state_next.tx_line &
            (state_next.tx_cnt >= PULSE_EDGE));
        // Write channel: address and data are taken in either order.
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata[7:0];
            state_next.w_strb0 = s_axi_wstrb[0];
        end
        if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = `USDP_RESP_OKAY;
            if (usdp_is_shadow(state_reg.aw_addr)) begin
                if (state_reg.w_strb0) begin
                    if (state_reg.fifo_en) begin
                        tx_push = 1'b1;
                    end else begin
                        state_next.tx_hold = state_reg.w_data;
                        state_next.tx_hold_valid = 1'b1;
                    end
                end
            end else if (state_reg.aw_addr == `USDP_CTRL_ADDR) begin
                if (state_reg.w_strb0) begin
                    state_next.fifo_en = state_reg.w_data[`USDP_CTRL_FIFO_EN_BIT];
                    state_next.ir_mode = state_reg.w_data[`USDP_CTRL_IR_MODE_BIT];
                    // Switching buffer mode discards stale characters of the old mode.
                    if (state_next.fifo_en != state_reg.fifo_en) begin
                        fifo_flush = 1'b1;
                        state_next.rx_hold_valid = 1'b0;
                        state_next.tx_hold_valid = 1'b0;
                    end
                end
            end else if (state_reg.aw_addr != `USDP_STAT_ADDR) begin
                state_next.bresp = `USDP_RESP_SLVERR;
            end
        end
        // Receiver samples mid-bit from the synchronised line.
        rx_line = state_reg.ir_mode ? state_reg.ir_sync : state_reg.sin_sync;
        case (state_reg.rx_state)
            USDP_LN_IDLE: begin
                if (!rx_line) begin
                    state_next.rx_cnt = HALF_M1;
                    state_next.rx_state = USDP_LN_START;
                end
            end
            USDP_LN_START: begin
                if (state_reg.rx_cnt == 16'h0000) begin
                    state_next.rx_cnt = BIT_M1;
                    state_next.rx_bit = 3'h0;
                    state_next.rx_state = rx_line ? USDP_LN_IDLE : USDP_LN_DATA;
                end else begin
                    state_next.rx_cnt = state_reg.rx_cnt - 16'h0001;
                end
            end
            USDP_LN_DATA: begin
                if (state_reg.rx_cnt == 16'h0000) begin
                    state_next.rx_cnt = BIT_M1;
                    state_next.rx_shift = {rx_line, state_reg.rx_shift[7:1]};
                    state_next.rx_bit = state_reg.rx_bit + 3'h1;
                    if (state_reg.rx_bit == 3'h7) begin
                        state_next.rx_state = USDP_LN_STOP;
                    end
                end else begin
                    state_next.rx_cnt = state_reg.rx_cnt - 16'h0001;
                end
            end
            USDP_LN_STOP: begin
                if (state_reg.rx_cnt == 16'h0000) begin
                    rx_done = rx_line;
                    state_next.rx_state = USDP_LN_IDLE;
                end else begin
                    state_next.rx_cnt = state_reg.rx_cnt - 16'h0001;
                end
            end
            default: begin
                state_next.rx_state = USDP_LN_IDLE;
            end
        endcase
        // A character that lands with a status read still raises overrun afterwards.
        if (rx_done && !fifo_flush) begin
            if (state_reg.fifo_en) begin
                rx_push = 1'b1;
                if (!rx_in_ready) begin
                    state_next.overrun = 1'b1;
                end
            end else begin
                if (state_next.rx_hold_valid) begin
                    state_next.overrun = 1'b1;
                end
                state_next.rx_hold = state_reg.rx_shift;
                state_next.rx_hold_valid = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
            state_reg.tx_state <= USDP_LN_IDLE;
            state_reg.rx_state <= USDP_LN_IDLE;
            state_reg.tx_line <= 1'b1;
            state_reg.tx_serial <= 1'b1;
            state_reg.tx_ir_n <= 1'b1;
            state_reg.sin_meta <= 1'b1;
            state_reg.sin_sync <= 1'b1;
            state_reg.ir_meta <= 1'b1;
            state_reg.ir_sync <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

//--- dv/usdp_top_chk.sv
// Assertion checker bound to the shadow data port top.
`timescale 1ns/1ps
module usdp_top_chk #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic tx_serial_o,
    input wire logic tx_infrared_n_o
);
    localparam int PULSE = (BIT_CYCLES * 3 / 16 > 0) ? BIT_CYCLES * 3 / 16 : 1;
    logic [15:0] ser_low_cnt;
    logic [15:0] ir_low_cnt;
    // Low runs are counted so that pulse and bit lengths can be judged when the line rises.
    always_ff @(posedge clk_sys_i) begin
        ser_low_cnt <= (sys_rst_i || tx_serial_o) ? 16'h0 : ser_low_cnt + 16'h1;
        ir_low_cnt <= (sys_rst_i || tx_infrared_n_o) ? 16'h0 : ir_low_cnt + 16'h1;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered in one cycle");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    a_ready_drop: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_line_excl: assert property (tx_serial_o || tx_infrared_n_o)
        else $error("both transmit outputs active");
    a_ir_pulse: assert property ($rose(tx_infrared_n_o) |-> ir_low_cnt == PULSE)
        else $error("infrared pulse length wrong");
    a_bit_run: assert property ($rose(tx_serial_o) |-> ser_low_cnt % BIT_CYCLES == 0)
        else $error("serial low run not whole bits");
    a_read_excl: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule
bind usdp_top usdp_top_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.clk_sys_i, .sys_rst_i,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .tx_serial_o,
    .tx_infrared_n_o);

//--- dv/usdp_line_partner.sv
// Remote line partner: frames characters toward the port and decodes what it sends.
`timescale 1ns/1ps
module usdp_line_partner #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic clk_sys_i,
    input wire logic tx_serial_i,
    input wire logic tx_infrared_n_i,
    output logic rx_serial_o = 1'b1,
    output logic rx_infrared_o = 1'b1
);
    logic [7:0] got[$];
    logic ir;
    logic z;
    logic [7:0] ch;
    task automatic send(input logic [7:0] c, input logic use_ir);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys_i);
            rx_serial_o <= f[i] | use_ir;
            rx_infrared_o <= f[i] | !use_ir;
            repeat (BIT_CYCLES - 1) @(posedge clk_sys_i);
        end
    endtask
    // Infrared zero is any pulse in the bit; serial is sampled mid-bit.
    initial begin
        forever begin
            @(negedge clk_sys_i);
            if (!tx_serial_i || !tx_infrared_n_i) begin
                ir = !tx_infrared_n_i;
                repeat (BIT_CYCLES - 1) @(negedge clk_sys_i);
                for (int b = 0; b < 8; b++) begin
                    z = 1'b0;
                    for (int c = 0; c < BIT_CYCLES; c++) begin
                        @(negedge clk_sys_i);
                        if (ir ? !tx_infrared_n_i : (c == BIT_CYCLES / 2 && !tx_serial_i))
                            z = 1'b1;
                    end
                    ch[b] = !z;
                end
                repeat (BIT_CYCLES - 1) @(negedge clk_sys_i);
                got.push_back(ch);
            end
        end
    end
endmodule

//--- dv/uart_shadow_data_port_test.sv
// Self-checking bench for the shadow data port.
`timescale 1ns/1ps
`include "usdp_consts.svh"
module uart_shadow_data_port_test;
    localparam int BC = 8;
    localparam logic [31:0] A0 = `USDP_SHADOW_BASE;
    localparam logic [31:0] ST = `USDP_STAT_ADDR;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic rx_serial_i, rx_infrared_i, tx_serial_o, tx_infrared_n_o;
    int n_fail = 0;
    int n_checks = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    usdp_top #(.BIT_CYCLES(BC), .TX_DEPTH(4)) u_dut (.clk_sys_i, .sys_rst_i, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rx_serial_i, .rx_infrared_i, .tx_serial_o, .tx_infrared_n_o);
    usdp_line_partner #(.BIT_CYCLES(BC)) u_line (.clk_sys_i, .tx_serial_i(tx_serial_o),
        .tx_infrared_n_i(tx_infrared_n_o), .rx_serial_o(rx_serial_i),
        .rx_infrared_o(rx_infrared_i));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Ready is sampled mid-cycle, where it equals what the next rising edge sees.
    task automatic acc(input logic w, input logic [31:0] a, d, input logic [1:0] er);
        logic ta, tw, td;
        logic [1:0] r;
        int k;
        k = 0;
        @(posedge clk_sys_i);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do begin
            @(negedge clk_sys_i);
            ta = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
            tw = s_axi_wvalid && s_axi_wready;
            td = w ? s_axi_bvalid : s_axi_rvalid;
            r = w ? s_axi_bresp : s_axi_rresp;
            v = s_axi_rdata;
            @(posedge clk_sys_i);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (tw)
                s_axi_wvalid <= 1'b0;
            k++;
        end while (!td && k < 50);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        chk(32'(r), 32'(er));
        chk(32'(td), 32'h1);
    endtask
    task automatic wrx(input int n);
        for (int k = 0; k < 4000 && u_line.got.size() < n; k++)
            @(posedge clk_sys_i);
        repeat (12 * BC) @(posedge clk_sys_i);
        chk(32'(u_line.got.size()), 32'(n));
    endtask
    task automatic t_tx_hold();
        acc(1, A0, 32'h0000_ff41, 2'b00);
        acc(1, A0 + 32'h4, 32'h42, 2'b00);
        acc(0, ST, 32'h0, 2'b00);
        chk(32'(v[`USDP_STAT_TX_HOLDING_EMPTY_BIT]), 32'h0);
        acc(1, A0 + 32'h2c, 32'h43, 2'b00);
        wrx(2);
        chk(32'(u_line.got[0]), 32'h41);
        chk(32'(u_line.got[1]), 32'h43);
        u_line.got.delete();
        $display("test tx_hold done");
    endtask
    task automatic t_rx_hold();
        u_line.send(8'h3c, 1'b0);
        u_line.send(8'h5a, 1'b0);
        repeat (BC) @(posedge clk_sys_i);
        acc(0, ST, 32'h0, 2'b00);
        chk(32'(v[1:0]), 32'h3);
        acc(0, A0 + 32'h2c, 32'h0, 2'b00);
        chk(v, 32'h5a);
        acc(0, ST, 32'h0, 2'b00);
        chk(32'(v[1:0]), 32'h0);
        acc(0, 32'h5000_1070, 32'h0, `USDP_RESP_SLVERR);
        chk(v, 32'h0);
        acc(1, 32'h5000_1070, 32'h0, `USDP_RESP_SLVERR);
        $display("test rx_hold done");
    endtask
    task automatic t_rx_fifo();
        acc(1, `USDP_CTRL_ADDR, 32'h3, 2'b00);
        acc(0, `USDP_CTRL_ADDR, 32'h0, 2'b00);
        chk(v, 32'h3);
        for (int i = 0; i < 9; i++)
            u_line.send(8'h10 + 8'(i), 1'b1);
        repeat (BC) @(posedge clk_sys_i);
        acc(0, ST, 32'h0, 2'b00);
        chk(32'(v[1]), 32'h1);
        for (int i = 0; i < 9; i++) begin
            acc(0, A0 + 32'(4 * i), 32'h0, 2'b00);
            chk(v, i < 8 ? 32'h10 + 32'(i) : 32'h0);
        end
        $display("test rx_fifo done");
    endtask
    task automatic t_tx_fifo();
        for (int i = 0; i < 6; i++)
            acc(1, A0 + 32'(4 * i), 32'h20 + 32'(i), 2'b00);
        wrx(5);
        for (int i = 0; i < 5; i++)
            chk(32'(u_line.got[i]), 32'h20 + 32'(i));
        $display("test tx_fifo done");
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_tx_hold();
        t_rx_hold();
        t_rx_fifo();
        t_tx_fifo();
        give_verdict();
    end
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        $display("unexpected timeout at %0t got %h exp %h", $time, 1'b0, 1'b1);
        n_fail++;
        give_verdict();
    end
endmodule
